/* design/i2c_intr_params.svh */
/*
  Offsets, field positions, reset values and widths of the two-wire
  controller's interrupt status and mask block.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef I2C_INTR_PARAMS_SVH
`define I2C_INTR_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define INTR_ADDR_W 12
`define MASK_OFS 12'h030
`define RAW_OFS 12'h034
`define RX_THR_OFS 12'h038
`define TX_THR_OFS 12'h03c
`define CLR_OFS 12'h040

// ----------------------------------------------------------------
// Field layout of status and mask
// ----------------------------------------------------------------
`define NUM_FLAGS 12
`define BIT_RX_UNDER 0
`define BIT_RX_OVER 1
`define BIT_RX_THR 2
`define BIT_TX_OVER 3
`define BIT_TX_THR 4
`define BIT_RD_REQ 5
`define BIT_TX_ABORT 6
`define BIT_RD_DONE 7
`define BIT_ACTIVITY 8
`define BIT_STOP 9
`define BIT_START 10
`define BIT_GENERAL_CALL_FLAG 11
`define THR_W 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MASK_RST 12'h8ff
`define THR_RST 8'h00
`define WORD_ZERO 32'h0000_0000

`endif

/* design/i2c_intr_pkg.sv */
/*
  Types shared by the interrupt status and mask block.
  Assumes the params header is on the include path.
*/
`include "i2c_intr_params.svh"

package i2c_intr_pkg;
  // ----------------------------------------------------------------
  // Vector types
  // ----------------------------------------------------------------
  typedef logic [`NUM_FLAGS-1:0] flag_vec_t;
  typedef logic [`THR_W-1:0] thr_t;
  typedef logic [31:0] word_t;
  typedef logic [`INTR_ADDR_W-1:0] addr_t;
endpackage

/* design/i2c_intr_status.sv */
/*
  Interrupt status and mask logic of the two-wire serial controller, with
  an APB slave for mask, raw status, thresholds and a clear register.
  Assumes the controller core drives its event pulses and FIFO levels on
  sys_clk, so no synchronisers are needed.
*/
// Local design decision: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "i2c_intr_params.svh"

// Functional notes
// R1: Mask register holds one enable per condition in bits 11:0; 31:12 reserved.
// R2: As slave transmitter, a byte not acknowledged by master sets read-done.
// R3: Bit 6 sets when transmitter cannot complete work on transmit FIFO contents.
// R4: Bit 5 sets when, as slave, another master tries to read.
// R5: Bit 4 is high while transmit fill level is at or below threshold.
// R6: Bit 3 sets on a command write while transmit buffer is full.
// R7: Bit 2 is high when receive fill level reaches or exceeds threshold.
// R8: Bit 1 sets when a byte arrives with receive buffer full.
// R9: Bit 0 sets on a data read while receive buffer is empty.
// R10: Receive and transmit thresholds are 8-bit software read-write fields.
// R11: Raw bits ignore the mask; only enabled conditions reach the interrupt.
module i2c_intr_status #(
  parameter int LVL_W = 9,
  parameter int TX_DEPTH = 8,
  parameter int RX_DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire i2c_intr_pkg::addr_t paddr,
  input wire i2c_intr_pkg::word_t pwdata,
  output i2c_intr_pkg::word_t prdata,
  output logic pready,
  output logic pslverr,
  // Controller core events and levels
  input wire logic [LVL_W-1:0] tx_fifo_level,
  input wire logic [LVL_W-1:0] rx_fifo_level,
  input wire logic data_command_wr,
  input wire logic data_command_rd,
  input wire logic rx_byte_in,
  input wire logic slave_mode,
  input wire logic slave_tx_mode,
  input wire logic byte_nack,
  input wire logic tx_abort_evt,
  input wire logic rd_req_evt,
  input wire logic general_call_evt,
  input wire logic start_evt,
  input wire logic stop_evt,
  input wire logic bus_active,
  // Interrupt and threshold outputs
  output logic intr_out,
  output i2c_intr_pkg::thr_t receive_threshold_level,
  output i2c_intr_pkg::thr_t transmit_threshold_level
);
  import i2c_intr_pkg::*;

  localparam logic [LVL_W-1:0] TX_FULL_LVL = LVL_W'(TX_DEPTH);
  localparam logic [LVL_W-1:0] RX_FULL_LVL = LVL_W'(RX_DEPTH);
  localparam logic [LVL_W-1:0] LVL_EMPTY = '0;

  flag_vec_t interrupt_mask_ff;
  flag_vec_t nxt_mask;
  thr_t receive_threshold_reg_ff;
  thr_t nxt_rx_thr;
  thr_t transmit_threshold_reg_ff;
  thr_t nxt_tx_thr;
  word_t prdata_ff;
  word_t nxt_prdata;
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic intr_ff;
  logic nxt_intr;
  flag_vec_t set_vec;
  flag_vec_t sticky_ff;
  flag_vec_t raw_interrupt_status;
  logic access_go;
  logic access_done;
  logic addr_ok;
  logic clr_read;
  logic tx_thr_hit;
  logic rx_thr_hit;

  // ----------------------------------------------------------------
  // Event capture
  // ----------------------------------------------------------------

  // Threshold conditions are levels; they follow the FIFO, not latched
  assign tx_thr_hit = tx_fifo_level <= {{(LVL_W-`THR_W){1'b0}}, transmit_threshold_reg_ff}; // [R5]
  assign rx_thr_hit = rx_fifo_level >= {{(LVL_W-`THR_W){1'b0}}, receive_threshold_reg_ff}; // [R7]

  // Pulse conditions feeding the sticky bank
  always_comb begin
    set_vec = '0;
    set_vec[`BIT_RX_UNDER] = data_command_rd && (rx_fifo_level == LVL_EMPTY); // [R9]
    set_vec[`BIT_RX_OVER] = rx_byte_in && (rx_fifo_level == RX_FULL_LVL); // [R8]
    set_vec[`BIT_TX_OVER] = data_command_wr && (tx_fifo_level == TX_FULL_LVL); // [R6]
    set_vec[`BIT_RD_REQ] = slave_mode && rd_req_evt; // [R4]
    set_vec[`BIT_TX_ABORT] = tx_abort_evt; // [R3]
    set_vec[`BIT_RD_DONE] = slave_tx_mode && byte_nack; // [R2]
    set_vec[`BIT_STOP] = stop_evt;
    set_vec[`BIT_START] = start_evt;
    set_vec[`BIT_GENERAL_CALL_FLAG] = general_call_evt;
  end

  // Read of the clear register drops every sticky bit at once
  sticky_flags #(
    .W(`NUM_FLAGS)
  ) u_flags (
    .sys_clk(sys_clk),
    .rst(rst),
    .set_vec(set_vec),
    .clr_all(clr_read),
    .flags_ff(sticky_ff)
  );

  // Raw view: the mask plays no part here
  always_comb begin
    raw_interrupt_status = sticky_ff; // [R11]
    raw_interrupt_status[`BIT_TX_THR] = tx_thr_hit;
    raw_interrupt_status[`BIT_RX_THR] = rx_thr_hit;
    raw_interrupt_status[`BIT_ACTIVITY] = bus_active;
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------

  // One wait state: data is prepared on the first access edge
  assign access_go = psel && penable && !pready_ff;
  assign access_done = psel && penable && pready_ff;
  assign clr_read = access_done && !pwrite && (paddr == `CLR_OFS);

  // Mapped offsets; the raw status and clear registers refuse writes
  always_comb begin
    unique case (paddr)
      `MASK_OFS, `RX_THR_OFS, `TX_THR_OFS: addr_ok = 1'b1;
      `RAW_OFS, `CLR_OFS: addr_ok = !pwrite;
      default: addr_ok = 1'b0;
    endcase
  end

  // Read mux and handshake; reserved bits read as zero
  always_comb begin
    nxt_prdata = prdata_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    if (access_go) begin
      nxt_pready = 1'b1;
      nxt_pslverr = !addr_ok;
      nxt_prdata = `WORD_ZERO;
      if (!pwrite) begin
        unique case (paddr)
          `MASK_OFS: nxt_prdata = {20'h00000, interrupt_mask_ff};
          `RAW_OFS: nxt_prdata = {20'h00000, raw_interrupt_status};
          `RX_THR_OFS: nxt_prdata = {24'h000000, receive_threshold_reg_ff};
          `TX_THR_OFS: nxt_prdata = {24'h000000, transmit_threshold_reg_ff};
          `CLR_OFS: nxt_prdata = {31'h00000000, |sticky_ff};
          default: nxt_prdata = `WORD_ZERO;
        endcase
      end
    end
  end

  // Writes land only at the edge that completes the transfer
  always_comb begin
    nxt_mask = interrupt_mask_ff;
    nxt_rx_thr = receive_threshold_reg_ff;
    nxt_tx_thr = transmit_threshold_reg_ff;
    if (access_done && pwrite) begin
      unique case (paddr)
        `MASK_OFS: nxt_mask = pwdata[`NUM_FLAGS-1:0]; // [R1]
        `RX_THR_OFS: nxt_rx_thr = pwdata[`THR_W-1:0]; // [R10]
        `TX_THR_OFS: nxt_tx_thr = pwdata[`THR_W-1:0]; // [R10]
        default: nxt_mask = interrupt_mask_ff;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------

  // Registered so the pin never glitches on a mask update
  always_comb begin
    nxt_intr = |(raw_interrupt_status & interrupt_mask_ff); // [R11]
  end

  // Register only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      interrupt_mask_ff <= `MASK_RST;
      receive_threshold_reg_ff <= `THR_RST;
      transmit_threshold_reg_ff <= `THR_RST;
      prdata_ff <= `WORD_ZERO;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      intr_ff <= 1'b0;
    end else begin
      interrupt_mask_ff <= nxt_mask;
      receive_threshold_reg_ff <= nxt_rx_thr;
      transmit_threshold_reg_ff <= nxt_tx_thr;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      intr_ff <= nxt_intr;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign intr_out = intr_ff;
  assign receive_threshold_level = receive_threshold_reg_ff;
  assign transmit_threshold_level = transmit_threshold_reg_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  mask_write_a: assert property ( // [R1]
    access_done && pwrite && paddr == `MASK_OFS |=> interrupt_mask_ff == $past(pwdata[11:0]))
    else $error("mask register did not take written value");
  read_done_a: assert property ( // [R2]
    slave_tx_mode && byte_nack |=> sticky_ff[`BIT_RD_DONE])
    else $error("read-done not set on unacknowledged byte");
  tx_abort_a: assert property ( // [R3]
    tx_abort_evt ##1 !clr_read |=> raw_interrupt_status[`BIT_TX_ABORT])
    else $error("transmit abort flag lost");
  rd_req_a: assert property ( // [R4]
    $rose(sticky_ff[`BIT_RD_REQ]) |-> $past(slave_mode) && $past(rd_req_evt))
    else $error("read request flag set without cause");
  tx_thr_a: assert property ( // [R5]
    raw_interrupt_status[`BIT_TX_THR] == (tx_fifo_level <= LVL_W'(transmit_threshold_reg_ff)))
    else $error("transmit threshold flag wrong");
  tx_over_a: assert property ( // [R6]
    $rose(sticky_ff[`BIT_TX_OVER]) |->
      $past(data_command_wr) && ($past(tx_fifo_level) == TX_FULL_LVL))
    else $error("transmit overflow flag wrong");
  rx_thr_a: assert property ( // [R7]
    raw_interrupt_status[`BIT_RX_THR] == (rx_fifo_level >= LVL_W'(receive_threshold_reg_ff)))
    else $error("receive threshold flag wrong");
  rx_over_a: assert property ( // [R8]
    rx_byte_in && rx_fifo_level == RX_FULL_LVL |=> sticky_ff[`BIT_RX_OVER])
    else $error("receive overflow flag not set");
  rx_under_a: assert property ( // [R9]
    data_command_rd && rx_fifo_level == LVL_EMPTY |=> sticky_ff[`BIT_RX_UNDER])
    else $error("receive underflow flag not set");
  thr_write_a: assert property ( // [R10]
    access_done && pwrite && paddr == `RX_THR_OFS |=> receive_threshold_reg_ff == $past(pwdata[7:0]))
    else $error("receive threshold not written");
  intr_gate_a: assert property ( // [R11]
    1'b1 |=> intr_out == |($past(raw_interrupt_status) & $past(interrupt_mask_ff)))
    else $error("interrupt output does not follow masked status");
  set_wins_a: assert property (
    clr_read && tx_abort_evt |=> sticky_ff[`BIT_TX_ABORT])
    else $error("event lost against clear");
  apb_ready_a: assert property (
    access_go |=> pready ##1 !pready)
    else $error("pready timing wrong");

  irq_cover_c: cover property (intr_out ##[1:20] clr_read);
  unmapped_cover_c: cover property (pready && pslverr);
  mask_cover_c: cover property (access_done && pwrite && paddr == `MASK_OFS);
  under_cover_c: cover property (set_vec[`BIT_RX_UNDER]);
endmodule

`default_nettype wire

/* design/sticky_flags.sv */
/*
  Bank of sticky event flags: a set pulse latches a bit, a clear drops all.
  Assumes set and clear come from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

module sticky_flags #(
  parameter int W = 12
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] set_vec,
  input wire logic clr_all,
  output logic [W-1:0] flags_ff
);
  logic [W-1:0] nxt_flags;

  // Set wins over a clear in the same cycle, so no event is lost
  always_comb begin
    nxt_flags = set_vec | (flags_ff & ~{W{clr_all}});
  end

  // Register only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end
endmodule

`default_nettype wire

/* sim/i2c_core_model.sv */
/*
  Model of the controller core beside the status block: FIFO levels,
  mode levels and one-cycle event pulses.
  Assumes its tasks are called right after a rising edge of sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none

module i2c_core_model (
  input wire logic sys_clk,
  output logic [8:0] tx_fifo_level,
  output logic [8:0] rx_fifo_level,
  output logic data_command_wr,
  output logic data_command_rd,
  output logic rx_byte_in,
  output logic slave_mode,
  output logic slave_tx_mode,
  output logic byte_nack,
  output logic tx_abort_evt,
  output logic rd_req_evt,
  output logic general_call_evt,
  output logic start_evt,
  output logic stop_evt,
  output logic bus_active
);
  // ----------------------------------------------------------------
  // Core stimulus
  // ----------------------------------------------------------------
  // Quiet core from time zero, so no input is ever unknown
  initial begin
    {tx_fifo_level, rx_fifo_level, bus_active, slave_mode, slave_tx_mode} = '0;
    {data_command_wr, data_command_rd, rx_byte_in, byte_nack} = '0;
    {tx_abort_evt, rd_req_evt, general_call_evt, start_evt, stop_evt} = '0;
  end

  // Live levels only
  task automatic set_lvl(input logic [8:0] t, input logic [8:0] r, input logic a);
    tx_fifo_level <= t;
    rx_fifo_level <= r;
    bus_active <= a;
  endtask

  // Codes 12 to 14 pulse an event with its condition absent
  task automatic fire(input int b);
    tx_fifo_level <= (b == 13) ? 9'h007 : 9'h008;
    rx_fifo_level <= (b == 1) ? 9'h008 : ((b == 14) ? 9'h001 : 9'h000);
    slave_mode <= (b == 5) || (b == 7);
    slave_tx_mode <= (b == 7);
    bus_active <= (b == 8);
    data_command_rd <= (b == 0) || (b == 14);
    rx_byte_in <= (b == 1);
    data_command_wr <= (b == 3) || (b == 13);
    rd_req_evt <= (b == 5) || (b == 12);
    tx_abort_evt <= (b == 6);
    byte_nack <= (b == 7);
    stop_evt <= (b == 9);
    start_evt <= (b == 10);
    general_call_evt <= (b == 11);
    @(posedge sys_clk);
    {data_command_wr, data_command_rd, rx_byte_in, byte_nack} <= '0;
    {tx_abort_evt, rd_req_evt, general_call_evt, start_evt, stop_evt} <= '0;
  endtask
endmodule

`default_nettype wire

/* sim/test_i2c_intr_status.sv */
/*
  Self-checking bench of the interrupt status and mask block over APB.
  Assumes the core model drives every core-side input.
*/
`timescale 1ns/10ps
`default_nettype none
`include "i2c_intr_params.svh"

module test_i2c_intr_status;
  import i2c_intr_pkg::*;

  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  addr_t paddr = '0;
  word_t pwdata = '0, prdata, rdat;
  logic pready, pslverr, intr_out, err;
  thr_t receive_threshold_level, transmit_threshold_level;
  logic [8:0] tx_fifo_level, rx_fifo_level;
  logic data_command_wr, data_command_rd, rx_byte_in, slave_mode, slave_tx_mode;
  logic byte_nack, tx_abort_evt, rd_req_evt, general_call_evt, start_evt;
  logic stop_evt, bus_active;
  int bad_count = 0, n_tests = 0, cyc = 0;
  int ev[13] = '{0, 1, 3, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14};

  i2c_intr_status u_i2c_intr_status (.sys_clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_fifo_level, .rx_fifo_level,
    .data_command_wr, .data_command_rd, .rx_byte_in, .slave_mode, .slave_tx_mode,
    .byte_nack, .tx_abort_evt, .rd_req_evt, .general_call_evt, .start_evt,
    .stop_evt, .bus_active, .intr_out, .receive_threshold_level,
    .transmit_threshold_level);

  i2c_core_model u_i2c_core_model (.sys_clk, .tx_fifo_level, .rx_fifo_level,
    .data_command_wr, .data_command_rd, .rx_byte_in, .slave_mode, .slave_tx_mode,
    .byte_nack, .tx_abort_evt, .rd_req_evt, .general_call_evt, .start_evt,
    .stop_evt, .bus_active);

  // ----------------------------------------------------------------
  // Clock, watchdog and helpers
  // ----------------------------------------------------------------
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (bad_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input word_t seen, input word_t exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the leading edge keeps two drives out of one step
  // Waits for pready however long it takes; only the watchdog ends a hang
  task automatic apb(input logic w, input addr_t a, input word_t d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, `MASK_OFS, '0);
    chk(rdat, 32'h0000_08ff);
    apb(1'b0, `RAW_OFS, '0);
    chk(rdat, 32'h0000_0014);
    apb(1'b1, `MASK_OFS, 32'hffff_ffff);
    apb(1'b0, `MASK_OFS, '0);
    chk(rdat, 32'h0000_0fff);
    apb(1'b1, `TX_THR_OFS, 32'h0000_0103);
    apb(1'b1, `RX_THR_OFS, 32'h0000_0005);
    apb(1'b0, `TX_THR_OFS, '0);
    chk(rdat, 32'h0000_0003);
    chk(word_t'(transmit_threshold_level), 32'h0000_0003);
    chk(word_t'(receive_threshold_level), 32'h0000_0005);
    // Levels one step past each threshold, then exactly on it
    u_i2c_core_model.set_lvl(9'h004, 9'h004, 1'b0);
    apb(1'b0, `RAW_OFS, '0);
    chk(rdat, '0);
    u_i2c_core_model.set_lvl(9'h003, 9'h005, 1'b1);
    apb(1'b0, `RAW_OFS, '0);
    chk(rdat, 32'h0000_0114);
    chk(word_t'(intr_out), 32'h0000_0001);
    apb(1'b1, `MASK_OFS, '0);
    apb(1'b0, `RAW_OFS, '0);
    chk(rdat, 32'h0000_0114);
    chk(word_t'(intr_out), '0);
    // Read-only status and an unmapped place are refused
    apb(1'b1, `RAW_OFS, 32'hffff_ffff);
    chk(word_t'(err), 32'h0000_0001);
    apb(1'b0, 12'h100, '0);
    chk(word_t'(err), 32'h0000_0001);
    // Each event alone, then cleared; codes above 11 must set nothing
    apb(1'b1, `MASK_OFS, 32'h0000_0fff);
    apb(1'b1, `TX_THR_OFS, '0);
    apb(1'b1, `RX_THR_OFS, 32'h0000_00ff);
    foreach (ev[i]) begin
      u_i2c_core_model.fire(ev[i]);
      apb(1'b0, `RAW_OFS, '0);
      chk(rdat, (ev[i] < 12) ? word_t'(1) << ev[i] : '0);
      chk(word_t'(intr_out), word_t'(ev[i] < 12));
      apb(1'b0, `CLR_OFS, '0);
      chk(rdat, word_t'(ev[i] < 12 && ev[i] != 8));
    end
    // Abort pulse lands on the very edge that completes a clear read
    fork
      apb(1'b0, `CLR_OFS, '0);
      begin
        repeat (3) @(posedge sys_clk);
        u_i2c_core_model.fire(6);
      end
    join
    chk(rdat, '0);
    apb(1'b0, `RAW_OFS, '0);
    chk(rdat, 32'h0000_0040);
    chk(word_t'(intr_out), 32'h0000_0001);
    // Mid-run reset drops the pending abort and restores mask and thresholds
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, `MASK_OFS, '0);
    chk(rdat, {20'h00000, `MASK_RST});
    chk(word_t'(receive_threshold_level), {24'h000000, `THR_RST});
    apb(1'b0, `RAW_OFS, '0);
    chk(rdat, 32'h0000_0004);
    chk(word_t'(intr_out), 32'h0000_0001);
    end_of_test();
  end
endmodule

`default_nettype wire
